// file: design/ocmem_pkg.sv
// Shared constants and carriers for the on-chip ROM/RAM bus slaves.
// Assumes a single pclk domain; imported whole by the top module.
package ocmem_pkg;
  localparam int SRC_W = 4;
  localparam int SZ_W  = 3;

  // TileLink A-channel opcodes
  localparam logic [2:0] OP_PUT_FULL = 3'h0;
  localparam logic [2:0] OP_PUT_PART = 3'h1;
  localparam logic [2:0] OP_ARITH    = 3'h2;
  localparam logic [2:0] OP_LOGIC    = 3'h3;
  localparam logic [2:0] OP_GET      = 3'h4;
  // TileLink D-channel opcodes
  localparam logic [2:0] OP_ACK      = 3'h0;
  localparam logic [2:0] OP_ACK_DATA = 3'h1;
  // Atomic parameters
  localparam logic [2:0] AR_MIN  = 3'h0;
  localparam logic [2:0] AR_MAX  = 3'h1;
  localparam logic [2:0] AR_MINU = 3'h2;
  localparam logic [2:0] AR_MAXU = 3'h3;
  localparam logic [2:0] AR_ADD  = 3'h4;
  localparam logic [2:0] LG_XOR  = 3'h0;
  localparam logic [2:0] LG_OR   = 3'h1;
  localparam logic [2:0] LG_AND  = 3'h2;
  localparam logic [2:0] LG_SWAP = 3'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ATTR     = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_ROM_CNT  = 8'h0C;
  localparam logic [7:0] REG_RAM_CNT  = 8'h10;
  // Field positions
  localparam int CTRL_ROM_EN  = 0;
  localparam int CTRL_RAM_EN  = 1;
  localparam int ATTR_CACHE   = 0;
  localparam int ATTR_EXEC    = 1;
  localparam int ATTR_ATOMIC  = 2;
  localparam int ATTR_AXI     = 3;
  localparam int ATTR_ROM_EX  = 4;
  localparam int ATTR_WIDTH   = 8;
  localparam int ST_ROM_DENY  = 0;
  localparam int ST_RAM_DENY  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef enum logic [1:0] {
    OCMEM_IDLE = 2'b01,
    OCMEM_RESP = 2'b10
  } ocmem_st_t;
  localparam int IDLE_BIT = 0;

  // TileLink header, shared by A and D channels
  typedef struct packed {
    logic [2:0]       opcode;
    logic [2:0]       param;
    logic [SZ_W-1:0]  size;
    logic [SRC_W-1:0] source;
  } ocmem_tl_hdr_t;
endpackage

// file: design/ocmem_top.sv
// On-chip ROM (TileLink-UL) and RAM (TileLink-UL or AXI4-Lite) slaves
// with an APB control/status block. Assumes one clock, upstream
// splitters for bursts, and one outstanding request per port.
// Operation
// - ROM answers TileLink reads with stored data, never alters it.
// - ROM decodes from a base address over a byte length.
// - ROM bytes fixed at elaboration by a per-byte generator function.
// - ROM data width is a byte parameter, default four.
// - ROM serves single-beat reads only; others are denied.
// - RAM holds data in storage, reads and writes via TileLink or AXI4.
// - RAM answers only its configured address range descriptor.
// - RAM port width is a byte parameter, default four.
// - RAM advertises cacheable and executable, both default permitted.
// - TileLink RAM accepts single-beat uncached lightweight requests only.
// - Atomics option adds logical and arithmetic operations; default off.
// - AXI RAM supports Lite only: no bursts, no narrow transfers.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module ocmem_top import ocmem_pkg::*; #(
  parameter int          PORT_BYTES = 4,
  parameter int          ADDR_W     = 32,
  parameter logic [31:0] ROM_BASE   = 32'h0000_0000,
  parameter int          ROM_BYTES  = 64,
  parameter bit          ROM_EXEC   = 1'b1,
  parameter logic [31:0] RAM_BASE   = 32'h0000_1000,
  parameter logic [31:0] RAM_MASK   = 32'h0000_0FFF,
  parameter bit          RAM_AXI    = 1'b0,
  parameter bit          ATOMICS    = 1'b0,
  parameter bit          CACHEABLE  = 1'b1,
  parameter bit          EXECUTABLE = 1'b1
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  // ROM TileLink port
  input  wire logic                    rom_a_valid,
  output logic                         rom_a_ready,
  input  wire ocmem_tl_hdr_t           rom_a_hdr,
  input  wire logic [ADDR_W-1:0]       rom_a_address,
  output logic                         rom_d_valid,
  input  wire logic                    rom_d_ready,
  output ocmem_tl_hdr_t                rom_d_hdr,
  output logic                         rom_d_denied,
  output logic [8*PORT_BYTES-1:0]      rom_d_data,
  // RAM TileLink port
  input  wire logic                    ram_a_valid,
  output logic                         ram_a_ready,
  input  wire ocmem_tl_hdr_t           ram_a_hdr,
  input  wire logic [ADDR_W-1:0]       ram_a_address,
  input  wire logic [PORT_BYTES-1:0]   ram_a_mask,
  input  wire logic [8*PORT_BYTES-1:0] ram_a_data,
  output logic                         ram_d_valid,
  input  wire logic                    ram_d_ready,
  output ocmem_tl_hdr_t                ram_d_hdr,
  output logic                         ram_d_denied,
  output logic [8*PORT_BYTES-1:0]      ram_d_data,
  // RAM AXI4-Lite port
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [8*PORT_BYTES-1:0] s_axi_wdata,
  input  wire logic [PORT_BYTES-1:0]   s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [8*PORT_BYTES-1:0]      s_axi_rdata,
  output logic [1:0]                   s_axi_rresp
);
  localparam int DW        = 8 * PORT_BYTES;
  localparam int LGW       = $clog2(PORT_BYTES);
  localparam int ROM_WORDS = ROM_BYTES / PORT_BYTES;
  localparam int ROM_IW    = $clog2(ROM_WORDS);
  localparam int RAM_WORDS = (int'(RAM_MASK) + 1) / PORT_BYTES;
  localparam int RAM_IW    = $clog2(RAM_WORDS);
  localparam logic [ADDR_W-1:0] RBASE = ADDR_W'(RAM_BASE);
  localparam logic [ADDR_W-1:0] RMASK = ADDR_W'(RAM_MASK);
  localparam logic [ADDR_W-1:0] OBASE = ADDR_W'(ROM_BASE);
  localparam logic [ADDR_W-1:0] OLEN  = ADDR_W'(ROM_BYTES);

  if (PORT_BYTES < 1 || (1 << LGW) != PORT_BYTES || PORT_BYTES > 8 ||
      ROM_WORDS < 2 || ROM_BYTES % PORT_BYTES != 0 || RAM_WORDS < 2 ||
      ((RAM_BASE & RAM_MASK) != 0)) begin : g_bad_cfg
    $error("ocmem_top: unsupported width, size or address range");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Default generator: each byte holds its own offset
  function automatic logic [7:0] rom_byte(input int i);
    return i[7:0];
  endfunction

  logic [DW-1:0] rom_mem [ROM_WORDS];
  logic [DW-1:0] ram_mem [RAM_WORDS];

  for (genvar w = 0; w < ROM_WORDS; w++) begin : g_rom_w
    for (genvar b = 0; b < PORT_BYTES; b++) begin : g_rom_b
      assign rom_mem[w][8*b +: 8] = rom_byte(w * PORT_BYTES + b);
    end
  end

  function automatic logic [DW-1:0] amo(input logic [2:0] op,
                                        input logic [2:0] prm,
                                        input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
    logic [DW-1:0] r;
    r = b;
    if (op == OP_ARITH) begin
      unique case (prm)
        AR_MIN:  r = ($signed(a) < $signed(b)) ? a : b;
        AR_MAX:  r = ($signed(a) > $signed(b)) ? a : b;
        AR_MINU: r = (a < b) ? a : b;
        AR_MAXU: r = (a > b) ? a : b;
        AR_ADD:  r = a + b;
        default: r = b;
      endcase
    end else if (op == OP_LOGIC) begin
      unique case (prm)
        LG_XOR:  r = a ^ b;
        LG_OR:   r = a | b;
        LG_AND:  r = a & b;
        default: r = b;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_r;
  logic [1:0]  status_r;
  logic [31:0] rom_cnt_r;
  logic [31:0] ram_cnt_r;
  logic [1:0]  deny_set;
  logic        rom_cnt_inc;
  logic        ram_cnt_inc;
  logic        apb_wr;
  logic [31:0] attr;

  assign apb_wr = psel & penable & pready & pwrite;
  assign attr   = {{(32 - ATTR_WIDTH - 4){1'b0}}, 4'(PORT_BYTES),
                   {(ATTR_WIDTH - ATTR_ROM_EX - 1){1'b0}}, ROM_EXEC,
                   RAM_AXI, ATOMICS, EXECUTABLE, CACHEABLE};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_wr && paddr == REG_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // Sticky deny flags; a new deny beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (apb_wr && paddr == REG_STATUS) begin
      status_r <= (status_r & ~pwdata[1:0]) | deny_set;
    end else begin
      status_r <= status_r | deny_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_cnt_r <= '0;
      ram_cnt_r <= '0;
    end else begin
      if (rom_cnt_inc) rom_cnt_r <= rom_cnt_r + 32'h1;
      if (ram_cnt_inc) ram_cnt_r <= ram_cnt_r + 32'h1;
    end
  end

  // APB: data captured at setup, pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= '0;
      unique case (paddr)
        REG_CTRL:    prdata <= {30'h0, ctrl_r};
        REG_ATTR:    prdata <= attr;
        REG_STATUS:  prdata <= {30'h0, status_r};
        REG_ROM_CNT: prdata <= rom_cnt_r;
        REG_RAM_CNT: prdata <= ram_cnt_r;
        default:     pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ROM TileLink slave
  // ----------------------------------------------------------------
  ocmem_st_t         rom_st_r;
  logic              rom_fire;
  logic [ADDR_W-1:0] rom_off;
  logic              rom_hit;
  logic              rom_ok;
  logic [ROM_IW-1:0] rom_idx;

  assign rom_a_ready = rom_st_r[IDLE_BIT];
  assign rom_fire    = rom_a_valid & rom_a_ready;
  assign rom_off     = rom_a_address - OBASE;
  assign rom_hit     = (rom_a_address >= OBASE) && (rom_off < OLEN);
  assign rom_idx     = rom_off[LGW +: ROM_IW];
  // Only single-beat Gets; anything that would write is refused
  assign rom_ok      = rom_hit && ctrl_r[CTRL_ROM_EN] &&
                       rom_a_hdr.opcode == OP_GET &&
                       rom_a_hdr.size <= SZ_W'(LGW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_st_r     <= OCMEM_IDLE;
      rom_d_valid  <= 1'b0;
      rom_d_hdr    <= '0;
      rom_d_denied <= 1'b0;
      rom_d_data   <= '0;
    end else begin
      unique case (rom_st_r)
        OCMEM_IDLE: if (rom_fire) begin
          rom_st_r         <= OCMEM_RESP;
          rom_d_valid      <= 1'b1;
          rom_d_hdr        <= rom_a_hdr;
          rom_d_hdr.opcode <= OP_ACK_DATA;
          rom_d_hdr.param  <= '0;
          rom_d_denied     <= !rom_ok;
          rom_d_data       <= rom_ok ? rom_mem[rom_idx] : '0;
        end
        OCMEM_RESP: if (rom_d_ready) begin
          rom_st_r    <= OCMEM_IDLE;
          rom_d_valid <= 1'b0;
        end
      endcase
    end
  end

  assign rom_cnt_inc = rom_fire & rom_ok;

  // ----------------------------------------------------------------
  // RAM TileLink slave
  // ----------------------------------------------------------------
  ocmem_st_t         ram_st_r;
  logic              tl_fire;
  logic              tl_ok;
  logic              tl_wr;
  logic              tl_amo;
  logic [RAM_IW-1:0] tl_idx;
  logic [DW-1:0]     tl_old;
  logic [DW-1:0]     tl_bits;

  // Address range descriptor: match when bits outside the mask equal base
  function automatic logic ram_hit(input logic [ADDR_W-1:0] a);
    return (a & ~RMASK) == RBASE;
  endfunction

  for (genvar b = 0; b < PORT_BYTES; b++) begin : g_mask
    assign tl_bits[8*b +: 8] = {8{ram_a_mask[b]}};
  end

  assign ram_a_ready = ram_st_r[IDLE_BIT] & !RAM_AXI;
  assign tl_fire     = ram_a_valid & ram_a_ready;
  assign tl_idx      = ram_a_address[LGW +: RAM_IW];
  assign tl_old      = ram_mem[tl_idx];
  assign tl_amo      = ram_a_hdr.opcode == OP_ARITH ||
                       ram_a_hdr.opcode == OP_LOGIC;
  assign tl_wr       = ram_a_hdr.opcode == OP_PUT_FULL ||
                       ram_a_hdr.opcode == OP_PUT_PART;
  // Atomics only full width, only when built in
  assign tl_ok = ram_hit(ram_a_address) && ctrl_r[CTRL_RAM_EN] &&
                 ram_a_hdr.size <= SZ_W'(LGW) &&
                 (tl_wr || ram_a_hdr.opcode == OP_GET ||
                  (tl_amo && ATOMICS &&
                   ram_a_hdr.size == SZ_W'(LGW)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_st_r     <= OCMEM_IDLE;
      ram_d_valid  <= 1'b0;
      ram_d_hdr    <= '0;
      ram_d_denied <= 1'b0;
      ram_d_data   <= '0;
    end else begin
      unique case (ram_st_r)
        OCMEM_IDLE: if (tl_fire) begin
          ram_st_r         <= OCMEM_RESP;
          ram_d_valid      <= 1'b1;
          ram_d_hdr        <= ram_a_hdr;
          ram_d_hdr.opcode <= tl_wr ? OP_ACK : OP_ACK_DATA;
          ram_d_hdr.param  <= '0;
          ram_d_denied     <= !tl_ok;
          ram_d_data       <= (tl_ok && !tl_wr) ? tl_old : '0;
        end
        OCMEM_RESP: if (ram_d_ready) begin
          ram_st_r    <= OCMEM_IDLE;
          ram_d_valid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // RAM AXI4-Lite slave
  // ----------------------------------------------------------------
  logic              aw_ok;
  logic              w_fire;
  logic              r_fire;
  logic              axi_wr_idle_r;
  logic              axi_rd_idle_r;
  logic [1:0]        w_resp;
  logic [1:0]        r_resp;

  assign s_axi_awready = axi_wr_idle_r;
  assign s_axi_wready  = axi_wr_idle_r;
  assign s_axi_arready = axi_rd_idle_r;
  // Address and data are taken together in one edge
  assign w_fire = s_axi_awvalid & s_axi_wvalid & axi_wr_idle_r;
  assign r_fire = s_axi_arvalid & axi_rd_idle_r;
  // Narrow writes refused; a partial strobe cannot be merged here
  assign w_resp = !ram_hit(s_axi_awaddr) ? RESP_DECERR :
                  (!ctrl_r[CTRL_RAM_EN] || !(&s_axi_wstrb)) ?
                  RESP_SLVERR : RESP_OKAY;
  assign r_resp = !ram_hit(s_axi_araddr) ? RESP_DECERR :
                  !ctrl_r[CTRL_RAM_EN] ? RESP_SLVERR : RESP_OKAY;
  assign aw_ok  = w_fire && w_resp == RESP_OKAY;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axi_wr_idle_r <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (!RAM_AXI) begin
      axi_wr_idle_r <= 1'b0;
    end else if (w_fire) begin
      axi_wr_idle_r <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= w_resp;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid  <= 1'b0;
      axi_wr_idle_r <= 1'b1;
    end else if (!s_axi_bvalid) begin
      axi_wr_idle_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axi_rd_idle_r <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
    end else if (!RAM_AXI) begin
      axi_rd_idle_r <= 1'b0;
    end else if (r_fire) begin
      axi_rd_idle_r <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= r_resp;
      s_axi_rdata   <= (r_resp == RESP_OKAY) ?
                       ram_mem[s_axi_araddr[LGW +: RAM_IW]] : '0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      axi_rd_idle_r <= 1'b1;
    end else if (!s_axi_rvalid) begin
      axi_rd_idle_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // RAM write port
  // ----------------------------------------------------------------
  // No reset on storage: contents are undefined after power-up
  always_ff @(posedge pclk) begin
    if (RAM_AXI && aw_ok) begin
      ram_mem[s_axi_awaddr[LGW +: RAM_IW]] <= s_axi_wdata;
    end else if (!RAM_AXI && tl_fire && tl_ok && tl_wr) begin
      ram_mem[tl_idx] <= (tl_old & ~tl_bits) | (ram_a_data & tl_bits);
    end else if (!RAM_AXI && tl_fire && tl_ok && tl_amo) begin
      ram_mem[tl_idx] <= amo(ram_a_hdr.opcode, ram_a_hdr.param,
                             tl_old, ram_a_data);
    end
  end

  assign ram_cnt_inc = (tl_fire & tl_ok) | aw_ok |
                       (r_fire && r_resp == RESP_OKAY);
  assign deny_set    = {(tl_fire & !tl_ok) | (w_fire & !aw_ok) |
                        (r_fire && r_resp != RESP_OKAY),
                        rom_fire & !rom_ok};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rom_resp_beat: assert property (rom_fire |=> rom_d_valid &&
    rom_d_hdr.source == $past(rom_a_hdr.source))
    else $error("ROM request without response beat");
  a_rom_no_write: assert property (
    rom_fire && rom_a_hdr.opcode != OP_GET |=> rom_d_denied)
    else $error("ROM accepted a non-read");
  a_rom_range: assert property (rom_fire && !rom_hit |=> rom_d_denied)
    else $error("ROM answered outside its range");
  a_rom_contents: assert property (rom_fire && rom_ok |=>
    rom_d_data == rom_mem[$past(rom_idx)])
    else $error("ROM data differs from generated contents");
  a_rom_single_beat: assert property (
    rom_fire && rom_a_hdr.size > SZ_W'(LGW) |=> rom_d_denied)
    else $error("ROM accepted a multi-beat read");
  a_ram_hold_resp: assert property (ram_d_valid && !ram_d_ready |=>
    ram_d_valid && $stable(ram_d_data) && !ram_a_ready)
    else $error("RAM response dropped under back-pressure");
  a_ram_range: assert property (
    tl_fire && !ram_hit(ram_a_address) |=> ram_d_denied)
    else $error("RAM answered outside its range");
  a_ram_single_beat: assert property (
    tl_fire && ram_a_hdr.size > SZ_W'(LGW) |=> ram_d_denied)
    else $error("RAM accepted a multi-beat request");
  a_ram_atomic_gate: assert property (
    tl_fire && tl_amo && !ATOMICS |=> ram_d_denied)
    else $error("Atomic accepted with atomics off");
  a_ram_write_read: assert property (
    tl_fire && tl_ok && ram_a_hdr.opcode == OP_PUT_FULL && (&ram_a_mask)
    |=> ram_mem[$past(tl_idx)] == $past(ram_a_data))
    else $error("RAM full write did not land in storage");
  a_axi_narrow: assert property (
    w_fire && !(&s_axi_wstrb) |=> s_axi_bvalid &&
    s_axi_bresp != RESP_OKAY)
    else $error("AXI narrow write not refused");
  a_attr_read: assert property (psel && !penable && paddr == REG_ATTR
    |=> prdata[ATTR_CACHE] == CACHEABLE && prdata[ATTR_EXEC] == EXECUTABLE)
    else $error("Attribute register wrong");

  c_rom_read: cover property (rom_fire && rom_ok ##1 rom_d_ready);
  c_ram_put: cover property (tl_fire && tl_ok && tl_wr);
  c_ram_amo: cover property (tl_fire && tl_ok && tl_amo);
  c_axi_write: cover property (aw_ok ##[1:4] s_axi_bvalid && s_axi_bready);
endmodule

// file: verification/ocmem_client.sv
// TileLink-UL client model driving one A/D port pair of the memory.
// Assumes the bench calls req() only after reset is released.
`timescale 1ns/1ns
module ocmem_client import ocmem_pkg::*; (
  // Clock
  input  wire logic        pclk,
  // A channel
  output logic             a_valid,
  input  wire logic        a_ready,
  output ocmem_tl_hdr_t    a_hdr,
  output logic [31:0]      a_address,
  output logic [3:0]       a_mask,
  output logic [31:0]      a_data,
  // D channel
  input  wire logic        d_valid,
  output logic             d_ready,
  input  wire logic        d_denied,
  input  wire logic [31:0] d_data
);
  initial begin
    a_valid = 1'b0;
    a_hdr = '0;
    a_address = '0;
    a_mask = 4'h0;
    a_data = '0;
    d_ready = 1'b0;
  end

  task automatic req(input logic [2:0] op, input logic [2:0] sz, input logic [31:0] ad,
                     input logic [31:0] dt, input int stall,
                     output logic [31:0] rd, output logic den);
    @(posedge pclk);
    a_valid <= 1'b1;
    a_hdr <= '{op, 3'h0, sz, 4'h5};
    a_address <= ad;
    a_data <= dt;
    a_mask <= 4'hF;
    do @(posedge pclk); while (a_ready !== 1'b1);
    a_valid <= 1'b0;
    // Released address and data lines flip so stale values cannot pass
    a_address <= ~ad;
    a_data <= ~dt;
    repeat (stall) @(posedge pclk);
    d_ready <= 1'b1;
    do @(posedge pclk); while (d_valid !== 1'b1);
    rd = d_data;
    den = d_denied;
    d_ready <= 1'b0;
  endtask
endmodule

// file: verification/test_ocmem_top.sv
// Self-checking bench for the on-chip memory slaves, TileLink RAM build.
// Assumes default parameters: ROM at 0 of 64 bytes, RAM at 0x1000..0x1FFF.
`timescale 1ns/1ns
module test_ocmem_top import ocmem_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, den, rav, rar, rdv, rdr, rdd, mav, mar, mdv, mdr, mdd;
  ocmem_tl_hdr_t rah, mah;
  logic [31:0] raa, rdt, maa, mad, mdt;
  logic [3:0] mam;
  // AXI side unused in this build
  logic ax0 = 1'b0;
  logic [31:0] axd = 32'h0;
  int mismatches = 0, n_tests = 0;
  always #4 pclk = ~pclk;

  ocmem_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .rom_a_valid(rav), .rom_a_ready(rar), .rom_a_hdr(rah),
    .rom_a_address(raa), .rom_d_valid(rdv), .rom_d_ready(rdr), .rom_d_hdr(),
    .rom_d_denied(rdd), .rom_d_data(rdt), .ram_a_valid(mav), .ram_a_ready(mar),
    .ram_a_hdr(mah), .ram_a_address(maa), .ram_a_mask(mam), .ram_a_data(mad),
    .ram_d_valid(mdv), .ram_d_ready(mdr), .ram_d_hdr(), .ram_d_denied(mdd),
    .ram_d_data(mdt), .s_axi_awvalid(ax0), .s_axi_awready(), .s_axi_awaddr(axd),
    .s_axi_wvalid(ax0), .s_axi_wready(), .s_axi_wdata(axd), .s_axi_wstrb(axd[3:0]),
    .s_axi_bvalid(), .s_axi_bready(ax0), .s_axi_bresp(), .s_axi_arvalid(ax0),
    .s_axi_arready(), .s_axi_araddr(axd), .s_axi_rvalid(), .s_axi_rready(ax0),
    .s_axi_rdata(), .s_axi_rresp());
  ocmem_client rom_u (.pclk(pclk), .a_valid(rav), .a_ready(rar), .a_hdr(rah),
    .a_address(raa), .a_mask(), .a_data(), .d_valid(rdv), .d_ready(rdr),
    .d_denied(rdd), .d_data(rdt));
  ocmem_client ram_u (.pclk(pclk), .a_valid(mav), .a_ready(mar), .a_hdr(mah),
    .a_address(maa), .a_mask(mam), .a_data(mad), .d_valid(mdv), .d_ready(mdr),
    .d_denied(mdd), .d_data(mdt));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    den = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b0, REG_ATTR, 32'h0);
    chk("attr", rd, 32'h0000_0413);
    chk("attr width", {28'h0, rd[11:8]}, 32'h4);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, den}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_rom();
    rom_u.req(OP_GET, 3'h2, 32'h4, 32'h0, 0, rd, den);
    chk("rom word 4", rd, 32'h0706_0504);
    chk("rom d hdr", dut_u.rom_d_hdr, {OP_ACK_DATA, 3'h0, 3'h2, 4'h5});
    rom_u.req(OP_GET, 3'h2, 32'h3C, 32'h0, 3, rd, den);
    chk("rom last word", rd, 32'h3F3E_3D3C);
    rom_u.req(OP_GET, 3'h2, 32'h40, 32'h0, 0, rd, den);
    chk("rom past end", {31'h0, den}, 32'h1);
    rom_u.req(OP_PUT_FULL, 3'h2, 32'h0, 32'hDEAD_BEEF, 0, rd, den);
    chk("rom put denied", {31'h0, den}, 32'h1);
    rom_u.req(OP_GET, 3'h2, 32'h0, 32'h0, 1, rd, den);
    chk("rom unchanged", rd, 32'h0302_0100);
    rom_u.req(OP_GET, 3'h3, 32'h0, 32'h0, 0, rd, den);
    chk("rom multi beat", {31'h0, den}, 32'h1);
    $display("test rom done");
  endtask

  task automatic t_ram();
    ram_u.req(OP_PUT_FULL, 3'h2, 32'h1000, 32'hA5A5_1234, 0, rd, den);
    chk("ram put ok", {31'h0, den}, 32'h0);
    chk("ram put ack", dut_u.ram_d_hdr.opcode, OP_ACK);
    ram_u.req(OP_PUT_FULL, 3'h2, 32'h1FFC, 32'h5A5A_C3C3, 2, rd, den);
    ram_u.req(OP_GET, 3'h2, 32'h1000, 32'h0, 0, rd, den);
    chk("ram read first", rd, 32'hA5A5_1234);
    ram_u.req(OP_GET, 3'h2, 32'h1FFC, 32'h0, 4, rd, den);
    chk("ram read last", rd, 32'h5A5A_C3C3);
    ram_u.req(OP_GET, 3'h2, 32'h2000, 32'h0, 0, rd, den);
    chk("ram out of range", {31'h0, den}, 32'h1);
    ram_u.req(OP_GET, 3'h3, 32'h1000, 32'h0, 0, rd, den);
    chk("ram multi beat", {31'h0, den}, 32'h1);
    ram_u.req(OP_ARITH, 3'h2, 32'h1000, 32'h1, 0, rd, den);
    chk("ram atomic off", {31'h0, den}, 32'h1);
    chk("axi idle", {dut_u.s_axi_awready, dut_u.s_axi_arready, dut_u.s_axi_bvalid,
      dut_u.s_axi_rvalid}, 32'h0);
    $display("test ram done");
  endtask

  task automatic t_status();
    apb(1'b0, REG_STATUS, 32'h0);
    chk("deny sticky", rd, 32'h3);
    apb(1'b1, REG_STATUS, 32'h3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("deny cleared", rd, 32'h0);
    apb(1'b0, REG_ROM_CNT, 32'h0);
    chk("rom good reads", rd, 32'h3);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl readback", rd, 32'h1);
    ram_u.req(OP_GET, 3'h2, 32'h1000, 32'h0, 0, rd, den);
    chk("ram disabled", {31'h0, den}, 32'h1);
    apb(1'b0, REG_RAM_CNT, 32'h0);
    chk("ram good ops", rd, 32'h4);
    $display("test status done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rom();
    t_ram();
    t_status();
    finish_test();
  end
endmodule
